// ### hw/drbc_regs.svh
// register offsets, field positions, reset values and timing counts of the dram bus control block
`ifndef DRBC_REGS_SVH
`define DRBC_REGS_SVH
`define DRBC_OFF_BUS_CTRL 16'hfed5
`define DRBC_OFF_DRAM_CTRL 16'hfed6
`define DRBC_OFF_REFR_CTRL 16'hfed4
`define DRBC_OFF_RAM_TYPE 16'hfed3
`define DRBC_OFF_EXT_SEL 16'hfed2
`define DRBC_OFF_CNT 16'hfed8
`define DRBC_OFF_COR 16'hfed9
`define DRBC_RST_BUS_CTRL 8'h2c
`define DRBC_RST_DRAM_CTRL 8'h00
`define DRBC_RST_REFR_CTRL 8'h00
`define DRBC_RST_RAM_TYPE 8'h00
`define DRBC_RST_EXT_SEL 8'h00
`define DRBC_RST_CNT 8'h00
`define DRBC_RST_COR 8'hff
`define DRBC_B_WAIT_PIN_ENABLE 0
`define DRBC_B_WRITE_BUFFER_ENABLE 1
`define DRBC_B_DDS 3
`define DRBC_B_EAE 5
`define DRBC_B_BUS_REQUEST_OUT_ENABLE 6
`define DRBC_B_BUS_RELEASE_ENABLE 7
`define DRBC_B_RLW 0
`define DRBC_B_MXC 2
`define DRBC_B_ROW_STROBE_DOWN_MODE 5
`define DRBC_B_BE 6
`define DRBC_B_TPC 7
`define DRBC_B_CKS 0
`define DRBC_B_COMPARE_IRQ_ENABLE 3
`define DRBC_B_CMF 4
`define DRBC_B_SELF_REFRESH_MODE 5
`define DRBC_B_RCW 6
`define DRBC_B_REFRESH_ENABLE 7
`define DRBC_B_WPS 0
`define DRBC_B_BPS 1
`define DRBC_PRE_W 12
`define DRBC_RAS_PULSE 2
`endif

// ### hw/drbc_pkg.sv
// types shared by the dram bus control block
package drbc_pkg;
   typedef enum logic [2:0] {
      DRBC_IDLE, DRBC_ROW, DRBC_WAIT, DRBC_RAS, DRBC_PRE
   } drbc_refr_type;
   typedef struct packed {
      logic wait_active;
      logic write_buffer_on;
      logic ack_late;
      logic page_mode;
      logic row_strobe_down;
      logic [3:0] mux_shift;
      logic two_state_precharge;
      logic [2:0] dram_areas;
      logic ext_window;
      logic self_refresh;
   } drbc_cfg_type;
   typedef struct packed {
      logic [7:0] bus_ctrl;
      logic [7:0] dram_ctrl;
      logic [7:0] refr_ctrl;
      logic [7:0] ram_type;
      logic [7:0] ext_sel;
      logic [7:0] cnt;
      logic [7:0] cor;
      logic flag_seen;
      logic [11:0] pre;
      drbc_refr_type st;
      logic [2:0] wcnt;
      logic ras_n;
      logic cas_n;
      logic refr_busy;
      logic irq;
      logic breq_p0;
      logic breq_p1;
      logic wait_a;
      logic wait_b;
      logic grant;
      logic wait_out;
      drbc_cfg_type cfg;
      logic [7:0] rdata;
      logic rvalid;
      logic waitreq;
   } drbc_state_type;
endpackage

// ### hw/drbc_top.sv
// dram refresh timer and external bus control settings behind an avalon-mm slave
`timescale 1ns/100ps
`default_nettype none
`include "drbc_regs.svh"

// Contract
// - wait input honoured only with wait_pin_enable; wait_pin_select picks the pin.
// - write_buffer_enable turns the write data buffer on or off.
// - ack timing select 0: dma to dram always full access, ack from row state.
// - ack timing select 1 with fast_page_enable: burst allowed, ack from first column state.
// - external_window_enable maps the window above 0x010000 to external space.
// - bus request output driven only when enabled; a select bit picks the pin.
// - external bus release granted only with bus_release_enable set.
// - refresh wait field adds zero to three waits to each refresh cycle.
// - multiplex field gives shift 8, 9 or 10; value 3 is reserved.
// - row strobe mode bit selects ras up (0) or ras down (1).
// - fast_page_enable allows fast page access, otherwise full access.
// - precharge length bit selects one or two precharge states.
// - clock select stops counter at 0, else divides by 2 up to 4096.
// - compare match flag sets when counter equals period constant.
// - compare interrupt asserted while flag set and interrupt enable set.
// - self_refresh_mode gives self-refresh in software standby.
// - row_column_wait adds one wait and delays ras to first column state.
// - refresh control only when refresh_enable is set.
// - 8-bit counter counts selected clock, read/write, resets to zero.
// - 8-bit period constant is read/write and resets to all ones.
// - ram type field marks none, area 2, 2-3 or 2-5 as dram space.
module drbc_top (
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst,
   // avalon-mm slave
   input wire logic [15:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [7:0] i_writedata,
   output logic [7:0] o_readdata,
   output logic o_readdatavalid,
   output logic o_waitrequest,
   // bus side pins and requests
   input wire logic i_wait_pin_a_n,
   input wire logic i_wait_pin_b_n,
   input wire logic i_bus_req_internal,
   input wire logic i_ext_release_req,
   // dram strobes
   output logic o_ras_n,
   output logic o_cas_n,
   output logic o_refresh_busy,
   // bus control outputs
   output logic o_wait_insert,
   output logic o_bus_request_out_p0_n,
   output logic o_bus_request_out_p1_n,
   output logic o_bus_grant,
   output logic o_compare_match_irq,
   output drbc_pkg::drbc_cfg_type o_cfg
);
   import drbc_pkg::*;

   drbc_state_type r;
   drbc_state_type n;
   logic tick;
   logic match;
   logic acc;
   logic [2:0] need;

   //----------------------------------------------------------------
   // divider tap select
   //----------------------------------------------------------------
   // tick is one cycle of the selected divided clock
   always_comb begin
      case (r.refr_ctrl[`DRBC_B_CKS +: 3])
         3'h1: tick = (r.pre[0:0] == 1'h1);
         3'h2: tick = (r.pre[2:0] == 3'h7);
         3'h3: tick = (r.pre[4:0] == 5'h1f);
         3'h4: tick = (r.pre[6:0] == 7'h7f);
         3'h5: tick = (r.pre[8:0] == 9'h1ff);
         3'h6: tick = (r.pre[10:0] == 11'h7ff);
         3'h7: tick = (r.pre == 12'hfff);
         default: tick = 1'b0;
      endcase
   end

   assign match = (r.cnt == r.cor);
   assign acc = (i_read | i_write) & ~r.waitreq;
   // total wait count in a refresh cycle
   assign need = {1'b0, r.dram_ctrl[`DRBC_B_RLW +: 2]} + {2'h0, r.refr_ctrl[`DRBC_B_RCW]};

   //----------------------------------------------------------------
   // next state
   //----------------------------------------------------------------
   // one pass of bus slave, timer, refresh sequencer and pin logic
   always_comb begin
      n = r;
      n.rvalid = 1'b0;
      // waitrequest idles high and drops for one cycle per request
      n.waitreq = 1'b1;
      // prescaler runs only while a clock is selected
      if (r.refr_ctrl[`DRBC_B_CKS +: 3] == 3'h0) begin
         n.pre = '0;
      end else begin
         n.pre = r.pre + 12'h001;
      end
      // counter advance and match clear
      if (tick) begin
         if (match) begin
            n.cnt = 8'h00;
         end else begin
            n.cnt = r.cnt + 8'h01;
         end
      end
      // register writes
      if (i_write && acc) begin
         case (i_address)
            `DRBC_OFF_BUS_CTRL: n.bus_ctrl = i_writedata & 8'heb;
            `DRBC_OFF_DRAM_CTRL: n.dram_ctrl = i_writedata & 8'hef;
            `DRBC_OFF_RAM_TYPE: n.ram_type = {5'h00, i_writedata[2:0]};
            `DRBC_OFF_EXT_SEL: n.ext_sel = {6'h00, i_writedata[1:0]};
            `DRBC_OFF_CNT: n.cnt = i_writedata;
            `DRBC_OFF_COR: n.cor = i_writedata;
            `DRBC_OFF_REFR_CTRL: begin
               n.refr_ctrl = i_writedata;
               // flag bit: 0 clears only after a read of 1, 1 is ignored
               n.refr_ctrl[`DRBC_B_CMF] = r.refr_ctrl[`DRBC_B_CMF];
               if (!i_writedata[`DRBC_B_CMF] && r.flag_seen) begin
                  n.refr_ctrl[`DRBC_B_CMF] = 1'b0;
                  n.flag_seen = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // register reads: data is staged while waitrequest is high, so that it
      // stands at the accepting edge; unmapped reads return zero
      if (i_read && r.waitreq) begin
         n.waitreq = 1'b0;
         n.rvalid = 1'b1;
         case (i_address)
            `DRBC_OFF_BUS_CTRL: n.rdata = r.bus_ctrl;
            `DRBC_OFF_DRAM_CTRL: n.rdata = r.dram_ctrl;
            `DRBC_OFF_RAM_TYPE: n.rdata = r.ram_type;
            `DRBC_OFF_EXT_SEL: n.rdata = r.ext_sel;
            `DRBC_OFF_CNT: n.rdata = r.cnt;
            `DRBC_OFF_COR: n.rdata = r.cor;
            `DRBC_OFF_REFR_CTRL: n.rdata = r.refr_ctrl;
            default: n.rdata = 8'h00;
         endcase
      end
      // writes need no staging and are let through on the next edge
      if (i_write && !i_read && r.waitreq) begin
         n.waitreq = 1'b0;
      end
      // only a flag handed over as 1 arms the clear
      if (i_read && acc && (i_address == `DRBC_OFF_REFR_CTRL) && r.rdata[`DRBC_B_CMF]) begin
         n.flag_seen = 1'b1;
      end
      // set wins over a clear in the same cycle
      if (tick && match) begin
         n.refr_ctrl[`DRBC_B_CMF] = 1'b1;
      end
      // cbr refresh sequencer: cas first, then ras after waits
      case (r.st)
         DRBC_IDLE: begin
            if (tick && match && r.refr_ctrl[`DRBC_B_REFRESH_ENABLE] && r.ram_type[2:0] != 3'h0) begin
               n.st = DRBC_ROW;
               n.cas_n = 1'b0;
               n.refr_busy = 1'b1;
               n.wcnt = 3'h0;
            end
         end
         DRBC_ROW: begin
            if (need == 3'h0) begin
               n.st = DRBC_RAS;
               n.ras_n = 1'b0;
               n.wcnt = 3'h0;
            end else begin
               n.st = DRBC_WAIT;
               n.wcnt = 3'h1;
            end
         end
         DRBC_WAIT: begin
            if (r.wcnt >= need) begin
               n.st = DRBC_RAS;
               n.ras_n = 1'b0;
               n.wcnt = 3'h0;
            end else begin
               n.wcnt = r.wcnt + 3'h1;
            end
         end
         DRBC_RAS: begin
            if (r.wcnt == 3'(`DRBC_RAS_PULSE - 1)) begin
               n.st = DRBC_PRE;
               n.ras_n = 1'b1;
               n.cas_n = 1'b1;
               n.wcnt = 3'h0;
            end else begin
               n.wcnt = r.wcnt + 3'h1;
            end
         end
         DRBC_PRE: begin
            if (r.wcnt == {2'h0, r.dram_ctrl[`DRBC_B_TPC]}) begin
               n.st = DRBC_IDLE;
               n.refr_busy = 1'b0;
            end else begin
               n.wcnt = r.wcnt + 3'h1;
            end
         end
         default: n.st = DRBC_IDLE;
      endcase
      // interrupt request level
      n.irq = r.refr_ctrl[`DRBC_B_CMF] & r.refr_ctrl[`DRBC_B_COMPARE_IRQ_ENABLE];
      // wait input gating and pin select
      n.wait_out = r.bus_ctrl[`DRBC_B_WAIT_PIN_ENABLE] &
         (r.ext_sel[`DRBC_B_WPS] ? ~i_wait_pin_b_n : ~i_wait_pin_a_n);
      // bus request pins, active low
      n.breq_p0 = ~(r.bus_ctrl[`DRBC_B_BUS_REQUEST_OUT_ENABLE] & ~r.ext_sel[`DRBC_B_BPS] & i_bus_req_internal);
      n.breq_p1 = ~(r.bus_ctrl[`DRBC_B_BUS_REQUEST_OUT_ENABLE] & r.ext_sel[`DRBC_B_BPS] & i_bus_req_internal);
      n.grant = r.bus_ctrl[`DRBC_B_BUS_RELEASE_ENABLE] & i_ext_release_req & ~r.refr_busy;
      // decoded configuration for the bus controller
      n.cfg.wait_active = r.bus_ctrl[`DRBC_B_WAIT_PIN_ENABLE];
      n.cfg.write_buffer_on = r.bus_ctrl[`DRBC_B_WRITE_BUFFER_ENABLE];
      n.cfg.ack_late = r.bus_ctrl[`DRBC_B_DDS] & r.dram_ctrl[`DRBC_B_BE];
      n.cfg.page_mode = r.dram_ctrl[`DRBC_B_BE];
      n.cfg.row_strobe_down = r.dram_ctrl[`DRBC_B_ROW_STROBE_DOWN_MODE];
      case (r.dram_ctrl[`DRBC_B_MXC +: 2])
         2'h0: n.cfg.mux_shift = 4'h8;
         2'h1: n.cfg.mux_shift = 4'h9;
         2'h2: n.cfg.mux_shift = 4'ha;
         default: n.cfg.mux_shift = 4'h0;
      endcase
      n.cfg.two_state_precharge = r.dram_ctrl[`DRBC_B_TPC];
      case (r.ram_type[2:0])
         3'h1: n.cfg.dram_areas = 3'h1;
         3'h2: n.cfg.dram_areas = 3'h3;
         3'h3: n.cfg.dram_areas = 3'h7;
         default: n.cfg.dram_areas = 3'h0;
      endcase
      n.cfg.ext_window = r.bus_ctrl[`DRBC_B_EAE];
      n.cfg.self_refresh = r.refr_ctrl[`DRBC_B_SELF_REFRESH_MODE];
   end

   //----------------------------------------------------------------
   // state register
   //----------------------------------------------------------------
   // all state in one struct, constant reset values
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         r <= '0;
         r.bus_ctrl <= `DRBC_RST_BUS_CTRL;
         r.dram_ctrl <= `DRBC_RST_DRAM_CTRL;
         r.refr_ctrl <= `DRBC_RST_REFR_CTRL;
         r.ram_type <= `DRBC_RST_RAM_TYPE;
         r.ext_sel <= `DRBC_RST_EXT_SEL;
         r.cnt <= `DRBC_RST_CNT;
         r.cor <= `DRBC_RST_COR;
         r.st <= DRBC_IDLE;
         r.ras_n <= 1'b1;
         r.cas_n <= 1'b1;
         r.breq_p0 <= 1'b1;
         r.breq_p1 <= 1'b1;
         r.waitreq <= 1'b1;
         r.cfg.mux_shift <= 4'h8;
         r.cfg.ext_window <= 1'b1;
      end else begin
         r <= n;
      end
   end

   //----------------------------------------------------------------
   // outputs
   //----------------------------------------------------------------
   // every output is a field of the state register
   assign o_readdata = r.rdata;
   assign o_readdatavalid = r.rvalid;
   assign o_waitrequest = r.waitreq;
   assign o_ras_n = r.ras_n;
   assign o_cas_n = r.cas_n;
   assign o_refresh_busy = r.refr_busy;
   assign o_wait_insert = r.wait_out;
   assign o_bus_request_out_p0_n = r.breq_p0;
   assign o_bus_request_out_p1_n = r.breq_p1;
   assign o_bus_grant = r.grant;
   assign o_compare_match_irq = r.irq;
   assign o_cfg = r.cfg;

   //----------------------------------------------------------------
   // assertions
   //----------------------------------------------------------------
   property p_irq;
      @(posedge i_mclk) disable iff (i_rst)
      (r.refr_ctrl[`DRBC_B_CMF] && r.refr_ctrl[`DRBC_B_COMPARE_IRQ_ENABLE]) |=> o_compare_match_irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");
   property p_flag_set;
      @(posedge i_mclk) disable iff (i_rst) (tick && match) |=> r.refr_ctrl[`DRBC_B_CMF];
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   property p_clr_need_read;
      @(posedge i_mclk) disable iff (i_rst)
      (r.refr_ctrl[`DRBC_B_CMF] && !r.flag_seen && !(i_read && acc)) |=> r.refr_ctrl[`DRBC_B_CMF];
   endproperty
   a_clr_need_read: assert property (p_clr_need_read) else $error("flag cleared early");
   property p_cnt_wrap;
      @(posedge i_mclk) disable iff (i_rst) (tick && match && !(i_write && acc)) |=> r.cnt == 8'h00;
   endproperty
   a_cnt_wrap: assert property (p_cnt_wrap) else $error("counter not cleared");
   property p_stop;
      @(posedge i_mclk) disable iff (i_rst)
      (r.refr_ctrl[2:0] == 3'h0 && !(i_write && acc)) |=> $stable(r.cnt);
   endproperty
   a_stop: assert property (p_stop) else $error("counter ran while stopped");
   property p_no_refr;
      @(posedge i_mclk) disable iff (i_rst)
      (r.st == DRBC_IDLE && !r.refr_ctrl[`DRBC_B_REFRESH_ENABLE]) |=> r.st == DRBC_IDLE;
   endproperty
   a_no_refr: assert property (p_no_refr) else $error("refresh while disabled");
   property p_ras_after_cas;
      @(posedge i_mclk) disable iff (i_rst) $fell(o_ras_n) |-> !o_cas_n;
   endproperty
   a_ras_after_cas: assert property (p_ras_after_cas) else $error("ras before cas");
   property p_grant;
      @(posedge i_mclk) disable iff (i_rst) o_bus_grant |-> $past(r.bus_ctrl[`DRBC_B_BUS_RELEASE_ENABLE]);
   endproperty
   a_grant: assert property (p_grant) else $error("grant while disabled");
   property p_breq;
      @(posedge i_mclk) disable iff (i_rst)
      (!o_bus_request_out_p0_n || !o_bus_request_out_p1_n) |-> $past(r.bus_ctrl[`DRBC_B_BUS_REQUEST_OUT_ENABLE]);
   endproperty
   a_breq: assert property (p_breq) else $error("request out while disabled");
   property p_breq_select;
      @(posedge i_mclk) disable iff (i_rst)
      !r.ext_sel[`DRBC_B_BPS] |=> o_bus_request_out_p1_n;
   endproperty
   a_breq_select: assert property (p_breq_select) else $error("request on unselected pin");
   property p_wait_gate;
      @(posedge i_mclk) disable iff (i_rst)
      !r.bus_ctrl[`DRBC_B_WAIT_PIN_ENABLE] |=> !o_wait_insert;
   endproperty
   a_wait_gate: assert property (p_wait_gate) else $error("wait inserted while disabled");
   property p_irq_masked;
      @(posedge i_mclk) disable iff (i_rst)
      !r.refr_ctrl[`DRBC_B_COMPARE_IRQ_ENABLE] |=> !o_compare_match_irq;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
   property p_flag_only_match;
      @(posedge i_mclk) disable iff (i_rst)
      (!r.refr_ctrl[`DRBC_B_CMF] && !(tick && match)) |=> !r.refr_ctrl[`DRBC_B_CMF];
   endproperty
   a_flag_only_match: assert property (p_flag_only_match) else $error("flag set without match");
   property p_cnt_step;
      @(posedge i_mclk) disable iff (i_rst)
      (tick && !match && !(i_write && acc)) |=> r.cnt == $past(r.cnt) + 8'h01;
   endproperty
   a_cnt_step: assert property (p_cnt_step) else $error("counter missed a tick");
   property p_strobe_busy;
      @(posedge i_mclk) disable iff (i_rst)
      (!o_ras_n || !o_cas_n) |-> o_refresh_busy;
   endproperty
   a_strobe_busy: assert property (p_strobe_busy) else $error("strobe outside refresh");
   property p_ras_width;
      @(posedge i_mclk) disable iff (i_rst)
      $fell(o_ras_n) |=> !o_ras_n ##1 o_ras_n;
   endproperty
   a_ras_width: assert property (p_ras_width) else $error("ras pulse width wrong");
   property p_precharge;
      @(posedge i_mclk) disable iff (i_rst)
      ($rose(o_ras_n) && !r.dram_ctrl[`DRBC_B_TPC]) |=> !o_refresh_busy;
   endproperty
   a_precharge: assert property (p_precharge) else $error("one state precharge too long");
   c_refresh: cover property (@(posedge i_mclk) disable iff (i_rst) $fell(o_ras_n));
   c_irq: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_compare_match_irq));
   c_clear: cover property (@(posedge i_mclk) disable iff (i_rst) $fell(r.refr_ctrl[`DRBC_B_CMF]));
   c_grant: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_bus_grant));
   c_wait: cover property (@(posedge i_mclk) disable iff (i_rst) $rose(o_wait_insert));
endmodule
`default_nettype wire

// ### verif/drbc_dram_model.sv
// behavioural model of the external dram and bus partner of the dram bus control block
`timescale 1ns/100ps
`default_nettype none
module drbc_dram_model (
   // clock
   input wire logic i_mclk,
   // dram strobes from the block
   input wire logic i_ras_n,
   input wire logic i_cas_n,
   // commands from the bench
   input wire logic i_hold_a,
   input wire logic i_hold_b,
   // wait pins towards the block, pulled up when released
   output logic o_wait_a_n,
   output logic o_wait_b_n,
   // refresh observations
   output var int o_refresh_count,
   output var int o_cas_to_ras,
   output var int o_ras_width
);
   int gap_cnt;
   int wid_cnt;
   logic ras_q;
   // memory holds the bus by pulling its wait pin low
   assign o_wait_a_n = !i_hold_a;
   assign o_wait_b_n = !i_hold_b;
   // start with nothing seen
   initial begin
      {o_refresh_count, o_cas_to_ras, o_ras_width, gap_cnt, wid_cnt} = '0;
      ras_q = 1'b1;
   end
   // cas low before ras marks a refresh; time strobe spacing and ras width
   always @(posedge i_mclk) begin
      if (i_cas_n) begin
         gap_cnt <= 0;
      end else if (i_ras_n) begin
         gap_cnt <= gap_cnt + 1;
      end
      if (!i_ras_n) begin
         wid_cnt <= wid_cnt + 1;
      end else if (wid_cnt != 0) begin
         o_ras_width <= wid_cnt;
         wid_cnt <= 0;
      end
      if (!i_ras_n && ras_q && !i_cas_n) begin
         o_refresh_count <= o_refresh_count + 1;
         o_cas_to_ras <= gap_cnt;
      end
      ras_q <= i_ras_n;
   end
endmodule
`default_nettype wire

// ### verif/drbc_top_tb_top.sv
// self-checking bench for the dram bus control block
`timescale 1ns/100ps
`default_nettype none
`include "drbc_regs.svh"
module drbc_top_tb_top;
   import drbc_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst = 1'b1;
   logic [15:0] address = 16'h0000;
   logic rd = 1'b0, wr = 1'b0, breq_in = 1'b0, rel_req = 1'b0, hold_a = 1'b0, hold_b = 1'b0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata, v, b;
   logic rvalid, waitreq, ras_n, cas_n, busy, busy_q, wins, bp0, bp1, grant, irq;
   logic wait_a_n, wait_b_n;
   logic [31:0] r;
   drbc_cfg_type cfg;
   int refr_cnt, cas_gap, ras_wid, g0, t0, t1, seed;
   int errors = 0, check_count = 0, cyc = 0;
   int model_reg [int];
   int rise_q [$];
   drbc_top u_drbc_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_address(address), .i_read(rd),
      .i_write(wr), .i_writedata(wdata), .o_readdata(rdata), .o_readdatavalid(rvalid),
      .o_waitrequest(waitreq), .i_wait_pin_a_n(wait_a_n), .i_wait_pin_b_n(wait_b_n),
      .i_bus_req_internal(breq_in), .i_ext_release_req(rel_req), .o_ras_n(ras_n),
      .o_cas_n(cas_n), .o_refresh_busy(busy), .o_wait_insert(wins),
      .o_bus_request_out_p0_n(bp0), .o_bus_request_out_p1_n(bp1), .o_bus_grant(grant),
      .o_compare_match_irq(irq), .o_cfg(cfg));
   drbc_dram_model u_drbc_dram_model (.i_mclk(i_mclk), .i_ras_n(ras_n), .i_cas_n(cas_n),
      .i_hold_a(hold_a), .i_hold_b(hold_b), .o_wait_a_n(wait_a_n), .o_wait_b_n(wait_b_n),
      .o_refresh_count(refr_cnt), .o_cas_to_ras(cas_gap), .o_ras_width(ras_wid));
   // clock
   always #12.5 i_mclk = ~i_mclk;
   // cycle count and refresh start times
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (busy === 1'b1 && busy_q !== 1'b1) begin
         rise_q.push_back(cyc);
      end
      busy_q <= busy;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // avalon write: hold until waitrequest sampled low, mirror the write (bus control reserved bits cleared)
   task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
      address <= a;
      wdata <= d;
      wr <= 1'b1;
      do begin @(posedge i_mclk); end while (waitreq !== 1'b0);
      wr <= 1'b0;
      if (model_reg.exists(a)) model_reg[a] = d & ((a == `DRBC_OFF_BUS_CTRL) ? 8'heb : 8'hff);
      @(posedge i_mclk);
   endtask
   // avalon read: hold until waitrequest sampled low, take the data at that edge
   task automatic rdchk(input logic [15:0] a, input logic [7:0] exp, input string what);
      address <= a;
      rd <= 1'b1;
      do begin @(posedge i_mclk); end while (waitreq !== 1'b0);
      chk(what, exp, rdata);
      chk("read valid", 1, rvalid);
      rd <= 1'b0;
      @(posedge i_mclk);
   endtask
   // run refresh timer and measure strobe spacing and refresh period
   task automatic refr(input logic [2:0] cks, input logic row_column_wait, input logic [1:0] rlw,
                       output int gap, output int per);
      bus_wr(`DRBC_OFF_DRAM_CTRL, {6'h00, rlw});
      bus_wr(`DRBC_OFF_REFR_CTRL, {1'b1, row_column_wait, 3'b001, cks});
      rise_q.delete();
      while (rise_q.size() < 3) begin @(posedge i_mclk); end
      gap = cas_gap;
      per = rise_q[2] - rise_q[1];
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge i_mclk);
      errors++;
      $display("watchdog expired");
      final_report();
   end
   // main sequence
   initial begin
      model_reg = '{16'hfed5: 8'h2c, 16'hfed6: 0, 16'hfed3: 0, 16'hfed2: 0, 16'hfed8: 0,
                    16'hfed9: 8'hff};
      seed = $urandom(32'hd64c);
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      @(posedge i_mclk);
      foreach (model_reg[k]) rdchk(16'(k), 8'(model_reg[k]), "reset value");
      rdchk(`DRBC_OFF_REFR_CTRL, 8'h00, "refresh control reset");
      bus_wr(16'hfed7, 8'h5a);
      rdchk(16'hfed7, 8'h00, "unmapped");
      $display("test reset done");
      for (int m = 0; m < 4; m++) begin
         r = $urandom;
         v = {r[7], m[0], r[5], 1'b0, 2'(m % 3), r[1:0]};
         b = {r[15:13], 1'b0, m[1], 1'b1, r[9], 1'b0};
         bus_wr(`DRBC_OFF_DRAM_CTRL, v);
         bus_wr(`DRBC_OFF_BUS_CTRL, b);
         bus_wr(`DRBC_OFF_RAM_TYPE, {5'h00, 3'(m)});
         bus_wr(`DRBC_OFF_COR, r[23:16]);
         bus_wr(`DRBC_OFF_REFR_CTRL, {2'b00, m[0], 5'h00});
         repeat (2) @(posedge i_mclk);
         chk("mux shift", 8 + m % 3, cfg.mux_shift);
         chk("page mode", v[6], cfg.page_mode);
         chk("ras down", v[5], cfg.row_strobe_down);
         chk("precharge", v[7], cfg.two_state_precharge);
         chk("write buffer", b[1], cfg.write_buffer_on);
         chk("ext window", b[5], cfg.ext_window);
         chk("ack late", b[3] & v[6], cfg.ack_late);
         chk("self refresh", m[0], cfg.self_refresh);
         chk("dram areas", (1 << m) - 1, cfg.dram_areas);
         foreach (model_reg[k]) rdchk(16'(k), 8'(model_reg[k]), "readback");
      end
      $display("test config done");
      for (int i = 0; i < 16; i++) begin
         hold_a <= i[2];
         hold_b <= i[3];
         breq_in <= i[2];
         rel_req <= i[3];
         bus_wr(`DRBC_OFF_EXT_SEL, {6'h00, i[1], i[1]});
         bus_wr(`DRBC_OFF_BUS_CTRL, {i[0], i[0], 5'h02, i[0]});
         repeat (2) @(posedge i_mclk);
         chk("wait insert", i[0] & (i[1] ? i[3] : i[2]), wins);
         chk("request pin 0", !(i[0] & !i[1] & i[2]), bp0);
         chk("request pin 1", !(i[0] & i[1] & i[2]), bp1);
         chk("bus grant", i[0] & i[3], grant);
         chk("wait enable", i[0], cfg.wait_active);
      end
      {hold_a, hold_b, breq_in, rel_req} <= 4'h0;
      $display("test pins done");
      bus_wr(`DRBC_OFF_RAM_TYPE, 8'h01);
      bus_wr(`DRBC_OFF_COR, 8'h07);
      refr(3'd1, 1'b0, 2'd0, g0, t0);
      chk("ras width", `DRBC_RAS_PULSE, ras_wid);
      chk("cas to ras base", 1, g0);
      for (int k = 1; k < 4; k++) begin
         refr(3'(k), 1'b0, 2'd0, t1, t0);
         chk("refresh period", 16 << (2 * (k - 1)), t0);
      end
      for (int k = 0; k < 8; k++) begin
         refr(3'd1, k[2], k[1:0], t1, t0);
         chk("cas to ras", g0 + k[2] + k[1:0], t1);
      end
      chk("irq with flag", 1, irq);
      $display("test refresh done");
      bus_wr(`DRBC_OFF_REFR_CTRL, 8'h88);
      bus_wr(`DRBC_OFF_CNT, 8'h05);
      rdchk(`DRBC_OFF_REFR_CTRL, 8'h98, "flag held");
      bus_wr(`DRBC_OFF_REFR_CTRL, 8'h88);
      rdchk(`DRBC_OFF_REFR_CTRL, 8'h88, "flag cleared");
      chk("irq cleared", 0, irq);
      repeat (20) @(posedge i_mclk);
      rdchk(`DRBC_OFF_CNT, 8'h05, "stopped counter");
      g0 = refr_cnt;
      bus_wr(`DRBC_OFF_REFR_CTRL, 8'h01);
      repeat (100) @(posedge i_mclk);
      chk("refresh count", g0, refr_cnt);
      rdchk(`DRBC_OFF_REFR_CTRL, 8'h11, "flag without refresh");
      chk("irq masked", 0, irq);
      $display("test flag done");
      final_report();
   end
endmodule
`default_nettype wire
